// ### rtl/twt_pkg.sv
// shared constants, field layout and types of the twin timer panel
// assumes a single 100 MHz clock and an AXI4-Lite register slave
package twt_pkg;
  // clock and derived cycle counts
  localparam int unsigned CLK_HZ = 100000000;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
  localparam int unsigned WIDE_MS = 20;   // long minimum input width
  localparam int unsigned NARROW_MS = 1;  // short minimum input width
  localparam int unsigned CHECK_MS = 2000; // mode check display time
  localparam int unsigned TICK_MS = 10;   // one count of elapsed time
  localparam int unsigned WIDE_CYC = WIDE_MS * CYC_PER_MS;
  localparam int unsigned NARROW_CYC = NARROW_MS * CYC_PER_MS;
  localparam int unsigned CHECK_CYC = CHECK_MS * CYC_PER_MS;
  localparam int unsigned TICK_CYC = TICK_MS * CYC_PER_MS;
  // time values: four decimal digits held in binary
  typedef logic [15:0] twt_time_t;
  localparam twt_time_t FULL_SCALE = 16'h270f;
  localparam twt_time_t SET_RST = 16'h0000;
  localparam twt_time_t DIGIT_W [4] = '{16'h0001, 16'h000a, 16'h0064, 16'h03e8};
  // operating modes, shared by both intervals
  typedef logic [2:0] twt_mode_t;
  localparam twt_mode_t MODE_RST = 3'h0;
  localparam twt_mode_t MODE_PWR1 = 3'h0; // power-on delay one
  localparam twt_mode_t MODE_PWR2 = 3'h1; // power_up_timing_two
  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_SET1 = 8'h04;
  localparam logic [7:0] OFF_SET2 = 8'h08;
  localparam logic [7:0] OFF_STAT = 8'h0c;
  localparam logic [7:0] OFF_ELAP = 8'h10;
  // control fields
  localparam int CTRL_DOWN = 0;   // 1: count-down direction
  localparam int CTRL_NARROW = 1; // 1: short input width accepted
  localparam logic [1:0] CTRL_RST = 2'h0;
  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  // front keys, all pins low when pressed
  typedef struct packed {
    logic fn;          // panel function key
    logic rstKey;      // reset key
    logic [3:0] up;    // per-digit up keys
    logic [3:0] dn;    // per-digit down keys
  } twt_keys_s;
  // contact inputs, all pins low when asserted
  typedef struct packed {
    logic start;
    logic stop;
    logic rstIn;
  } twt_ins_s;
  // panel states
  typedef enum logic [2:0] {
    P_NORMAL = 3'b001,
    P_MODESET = 3'b010,
    P_CHECK = 3'b100
  } twt_panel_e;
  // timing states
  typedef enum logic [2:0] {
    T_IDLE = 3'b001,
    T_RUN1 = 3'b010,
    T_RUN2 = 3'b100
  } twt_run_e;
endpackage

// ### rtl/twt_in_filter.sv
// one input conditioner: two-stage synchroniser and width filter
// assumes a raw active-low pin from outside the clock domain
module twt_in_filter #(
  parameter int unsigned WIDE = twt_pkg::WIDE_CYC,
  parameter int unsigned NARROW = twt_pkg::NARROW_CYC
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic pinN,
  input wire logic narrow,
  output logic level,
  output logic press
);
  logic syncA; // first stage, read only by syncB
  logic syncB;
  logic [31:0] run; // cycles the new level has held
  logic [31:0] need;

  assign need = narrow ? 32'(NARROW) : 32'(WIDE);

  // synchroniser, idle pin is high
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      syncA <= 1'b1;
      syncB <= 1'b1;
    end else begin
      syncA <= pinN;
      syncB <= syncA;
    end
  end

  // RULE20 width filter
  // RULE16 low pin means asserted
  // a level change is only taken once it held the full width,
  // so bounce shorter than the width never reaches the timer
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      run <= 32'h0;
      level <= 1'b0;
      press <= 1'b0;
    end else begin
      press <= 1'b0;
      if (~syncB == level) begin
        run <= 32'h0;
      end else if (run >= need - 32'h1) begin
        run <= 32'h0;
        level <= ~syncB;
        press <= ~syncB;
      end else begin
        run <= run + 32'h1;
      end
    end
  end
endmodule

// ### rtl/twt_panel_timer.sv
// twin-interval timer: key panel, timing core and register slave
// assumes raw active-low key and input pins, AXI4-Lite master
// Behaviour
// RULE1 - function key plus digit-one key: mode setting
// RULE2 - digit-one up steps left, down steps right
// RULE3 - reset key stores shown mode, returns normal
// RULE4 - function key alone toggles shown interval
// RULE5 - function plus digit-two shows mode two seconds
// RULE6 - function plus digit-four locks; keys ignored (code: lone function key toggle and mode check still act)
// RULE7 - same combination again clears the lock
// RULE8 - mode, direction, width shared by intervals
// RULE9 - interval display toggle never disturbs timing
// RULE10 - count-up edit below elapsed wraps full scale
// RULE11 - count-up edit above elapsed ends there
// RULE12 - count-down always runs to zero
// RULE13 - both sets zero: output follows start
// RULE14 - reset input forces output off
// RULE15 - contacts hold 20 ms, bounce short
// RULE16 - input asserted when pin pulled low
// RULE17 - power-up start only in power modes
// RULE18 - switch selects 20 ms or 1 ms width
// RULE19 - unlocked reset key clears time and output
// RULE20 - pulses shorter than width are rejected
//
// Local design decisions: the AXI4-Lite register port and the address map.
module twt_panel_timer #(
  parameter int unsigned WIDE = twt_pkg::WIDE_CYC,
  parameter int unsigned NARROW = twt_pkg::NARROW_CYC,
  parameter int unsigned CHECK = twt_pkg::CHECK_CYC,
  parameter int unsigned TICK = twt_pkg::TICK_CYC
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire twt_pkg::twt_keys_s keysN,
  input wire twt_pkg::twt_ins_s insN,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic ctlOut,
  output logic showSel,
  output logic lock,
  output logic [2:0] shownMode
);
  import twt_pkg::*;

  logic [12:0] pinVec; // keys above inputs
  logic [12:0] lvlVec; // filtered levels
  logic [12:0] prsVec; // assertion pulses
  twt_keys_s kLvl; // key held
  twt_keys_s kPrs; // key pressed this cycle
  twt_ins_s iLvl; // input asserted
  twt_ins_s iPrs; // input newly asserted
  logic [1:0] ctrl; // direction and width
  twt_time_t set1; // first_interval_timer set
  twt_time_t set2; // second_interval_timer set
  twt_time_t cnt; // elapsed or residual time
  twt_panel_e panel;
  twt_run_e st;
  twt_mode_t opMode; // committed operating mode
  logic [31:0] chkCnt; // mode check display time
  logic [31:0] tickCnt; // time base divider
  logic fnPrev; // function key level last cycle
  logic comboUsed; // function key used with another key
  logic pwrArm; // power-up start armed until set times appear

  assign pinVec = {keysN, insN};
  assign kLvl = twt_keys_s'(lvlVec[12:3]);
  assign kPrs = twt_keys_s'(prsVec[12:3]);
  assign iLvl = twt_ins_s'(lvlVec[2:0]);
  assign iPrs = twt_ins_s'(prsVec[2:0]);

  // one conditioner per pin; keys always use the long width
  genvar gi;
  generate
    for (gi = 0; gi < 13; gi++) begin : g_in
      // RULE18 width select
      twt_in_filter #(
        .WIDE(WIDE),
        .NARROW(NARROW)
      ) u_flt (
        .ref_clk(ref_clk),
        .rst(rst),
        .pinN(pinVec[gi]),
        .narrow(gi < 3 ? ctrl[CTRL_NARROW] : 1'b0),
        .level(lvlVec[gi]),
        .press(prsVec[gi])
      );
    end
  endgenerate

  // key combinations
  logic dig0; // first-digit up or down pressed
  logic dig1;
  logic dig3;
  logic fnCombo; // function key held with a digit key
  assign dig0 = kPrs.up[0] | kPrs.dn[0];
  assign dig1 = kPrs.up[1] | kPrs.dn[1];
  assign dig3 = kPrs.up[3] | kPrs.dn[3];
  assign fnCombo = kLvl.fn & (|{kPrs.up, kPrs.dn});

  // panel state, shown and committed mode
  // entering mode setting is refused while locked, since it
  // would let the up and down keys act through the lock
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      panel <= P_NORMAL;
      shownMode <= MODE_RST;
      opMode <= MODE_RST;
      chkCnt <= 32'h0;
    end else begin
      unique case (panel)
        P_NORMAL: begin
          // RULE1 enter mode setting
          if (kLvl.fn && dig0 && !lock) begin
            panel <= P_MODESET;
            shownMode <= opMode;
          // RULE5 start mode check
          end else if (kLvl.fn && dig1) begin
            panel <= P_CHECK;
            shownMode <= opMode;
            chkCnt <= 32'h0;
          end
        end
        P_MODESET: begin
          // RULE3 commit shown mode
          if (kPrs.rstKey) begin
            opMode <= shownMode;
            panel <= P_NORMAL;
          // RULE2 step mode left
          end else if (kPrs.up[0]) begin
            shownMode <= shownMode - 3'h1;
          end else if (kPrs.dn[0]) begin
            shownMode <= shownMode + 3'h1;
          end
        end
        P_CHECK: begin
          // RULE5 two second view
          if (chkCnt == 32'(CHECK - 1)) begin
            panel <= P_NORMAL;
          end else begin
            chkCnt <= chkCnt + 32'h1;
          end
        end
      endcase
    end
  end

  // lock toggles on each function plus fourth-digit press in the normal panel state
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      lock <= 1'b0;
    end else if (panel == P_NORMAL && kLvl.fn && dig3) begin
      // RULE6 RULE7 lock toggle
      lock <= ~lock;
    end
  end

  // interval display toggles on a lone function key release;
  // release is used so a combination does not also toggle
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      showSel <= 1'b0;
      fnPrev <= 1'b0;
      comboUsed <= 1'b0;
    end else begin
      fnPrev <= kLvl.fn;
      if (kPrs.fn) begin
        comboUsed <= 1'b0;
      end else if (fnCombo || (kLvl.fn && kPrs.rstKey)) begin
        comboUsed <= 1'b1;
      end
      // RULE4 RULE9 display toggle only
      if (fnPrev && !kLvl.fn && !comboUsed) begin
        showSel <= ~showSel;
      end
    end
  end

  // key edit of the displayed set time
  logic editUp;
  logic editDn;
  twt_time_t editW; // weight of the pressed digit
  twt_time_t curEdit;
  logic [16:0] sumUp;
  twt_time_t newVal;
  logic editOk;
  always_comb begin
    editUp = 1'b0;
    editDn = 1'b0;
    editW = 16'h0000;
    for (int i = 3; i >= 0; i--) begin
      if (kPrs.up[i] || kPrs.dn[i]) begin
        editW = DIGIT_W[i];
        editUp = kPrs.up[i];
        editDn = kPrs.dn[i] & ~kPrs.up[i];
      end
    end
  end
  // RULE6 locked keys ignored
  assign editOk = panel == P_NORMAL && !kLvl.fn && !lock && (editUp || editDn);
  assign curEdit = showSel ? set2 : set1;
  assign sumUp = {1'b0, curEdit} + {1'b0, editW};
  // saturate at full scale and at zero rather than wrap
  always_comb begin
    if (editUp) begin
      newVal = sumUp > {1'b0, FULL_SCALE} ? FULL_SCALE : sumUp[15:0];
    end else begin
      newVal = curEdit < editW ? 16'h0000 : curEdit - editW;
    end
  end

  // bus write channel state
  logic [7:0] awAddr; // held write address
  logic [31:0] wData; // held write data
  logic [3:0] wStrb;
  logic doWr; // both halves held, answer not yet given
  logic wrOk; // address is a writable register, status or elapsed time
  assign doWr = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign wrOk = awAddr inside {OFF_CTRL, OFF_SET1, OFF_SET2, OFF_STAT, OFF_ELAP};

  // byte-lane merge of a write into an old value
  function automatic logic [31:0] merge(
    input logic [31:0] old,
    input logic [31:0] nw,
    input logic [3:0] strb
  );
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction

  // merged write values as nets, so that a field can be sliced out
  logic [31:0] ctrlNew;
  logic [31:0] set1New;
  logic [31:0] set2New;
  assign ctrlNew = merge({30'h0, ctrl}, wData, wStrb);
  assign set1New = merge({16'h0, set1}, wData, wStrb);
  assign set2New = merge({16'h0, set2}, wData, wStrb);

  // control register: shared by both intervals
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctrl <= CTRL_RST;
    end else if (doWr && awAddr == OFF_CTRL) begin
      // RULE8 single shared settings
      ctrl <= ctrlNew[1:0];
    end
  end

  // set times; a bus write wins over a key in the same cycle
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      set1 <= SET_RST;
      set2 <= SET_RST;
    end else if (doWr && awAddr == OFF_SET1) begin
      set1 <= set1New[15:0];
    end else if (doWr && awAddr == OFF_SET2) begin
      set2 <= set2New[15:0];
    end else if (editOk && !showSel) begin
      set1 <= newVal;
    end else if (editOk) begin
      set2 <= newVal;
    end
  end

  // timing core
  logic clr; // reset input or unlocked reset key
  logic zeroSets;
  logic down;
  logic powerMode;
  twt_time_t runSet; // set time of the running interval
  twt_time_t nextSet; // set time of the following interval
  twt_time_t upNext;
  logic phaseEnd;
  // RULE19 unlocked reset key
  assign clr = iLvl.rstIn | (kPrs.rstKey & ~lock & panel == P_NORMAL);
  assign zeroSets = set1 == 16'h0000 && set2 == 16'h0000;
  assign down = ctrl[CTRL_DOWN];
  assign powerMode = opMode == MODE_PWR1 || opMode == MODE_PWR2;
  assign runSet = st == T_RUN1 ? set1 : set2;
  assign nextSet = st == T_RUN1 ? set2 : set1;
  // RULE10 wrap at full scale
  assign upNext = cnt == FULL_SCALE ? 16'h0000 : cnt + 16'h1;
  // RULE11 RULE12 end points
  assign phaseEnd = down ? cnt <= 16'h0001 : upNext == runSet;

  // intervals alternate: first off, second on, then repeat
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st <= T_IDLE;
      cnt <= 16'h0000;
      tickCnt <= 32'h0;
      pwrArm <= 1'b1;
    end else begin
      // set times clear at reset, so the arm waits for the first
      // nonzero set; otherwise a power-on mode could never start
      pwrArm <= pwrArm & zeroSets;
      if (clr || zeroSets) begin
        st <= T_IDLE;
        cnt <= 16'h0000;
        tickCnt <= 32'h0;
      // RULE17 power-up start only in power modes
      end else if (iPrs.start || (pwrArm && powerMode)) begin
        st <= T_RUN1;
        cnt <= down ? set1 : 16'h0000;
        tickCnt <= 32'h0;
      end else if (st != T_IDLE && !iLvl.stop) begin
        if (tickCnt == 32'(TICK - 1)) begin
          tickCnt <= 32'h0;
          if (phaseEnd) begin
            st <= st == T_RUN1 ? T_RUN2 : T_RUN1;
            cnt <= down ? nextSet : 16'h0000;
          end else begin
            cnt <= down ? cnt - 16'h1 : upNext;
          end
        end else begin
          tickCnt <= tickCnt + 32'h1;
        end
      end
    end
  end

  // controlled output
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctlOut <= 1'b0;
    // RULE14 reset input forces off
    end else if (clr) begin
      ctlOut <= 1'b0;
    // RULE13 start-driven output
    end else if (zeroSets) begin
      ctlOut <= iLvl.start;
    end else begin
      ctlOut <= st == T_RUN2;
    end
  end

  // write channel: address and data taken in either order
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      awAddr <= 8'h00;
      wData <= 32'h0;
      wStrb <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awAddr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      // read-only registers accept and ignore writes
      if (doWr) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wrOk ? RESP_OKAY : RESP_DECERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // read channel: one read under way at a time
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      unique case (s_axi_araddr)
        OFF_CTRL: s_axi_rdata <= {30'h0, ctrl};
        OFF_SET1: s_axi_rdata <= {16'h0, set1};
        OFF_SET2: s_axi_rdata <= {16'h0, set2};
        OFF_STAT: s_axi_rdata <= {20'h0, st, panel, opMode, ctlOut, lock, showSel};
        OFF_ELAP: s_axi_rdata <= {16'h0, cnt};
        default: begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= RESP_DECERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // checks
  AST_MODESET_ENTRY: assert property (@(posedge ref_clk) disable iff (rst) // RULE1
    (panel == P_NORMAL && kLvl.fn && dig0 && !lock) |=> panel == P_MODESET)
    else $error("mode setting not entered");
  AST_MODE_STEP: assert property (@(posedge ref_clk) disable iff (rst) // RULE2
    (panel == P_MODESET && kPrs.dn[0] && !kPrs.up[0] && !kPrs.rstKey)
    |=> shownMode == $past(shownMode) + 3'h1)
    else $error("down key did not step mode right");
  AST_MODE_COMMIT: assert property (@(posedge ref_clk) disable iff (rst) // RULE3
    (panel == P_MODESET && kPrs.rstKey)
    |=> panel == P_NORMAL && opMode == $past(shownMode))
    else $error("mode not stored on reset key");
  AST_CHECK_VIEW: assert property (@(posedge ref_clk) disable iff (rst) // RULE5
    (panel == P_NORMAL && kLvl.fn && dig1 && !(dig0 && !lock))
    |=> (panel == P_CHECK)[*8])
    else $error("mode check view ended early");
  AST_CHECK_END: assert property (@(posedge ref_clk) disable iff (rst) // RULE5
    (panel == P_CHECK && chkCnt == 32'(CHECK - 1)) |=> panel == P_NORMAL)
    else $error("mode check view did not end");
  AST_LOCK_HOLD: assert property (@(posedge ref_clk) disable iff (rst) // RULE6
    (lock && !kLvl.fn && !doWr && (|kPrs.up)) |=> $stable(set1) && $stable(set2))
    else $error("set time edited while locked");
  AST_LOCK_FLIP: assert property (@(posedge ref_clk) disable iff (rst) // RULE7
    (panel == P_NORMAL && kLvl.fn && dig3) |=> lock != $past(lock))
    else $error("lock did not toggle");
  AST_ZERO_OUT: assert property (@(posedge ref_clk) disable iff (rst) // RULE13
    (zeroSets && !clr) |=> ctlOut == $past(iLvl.start))
    else $error("zero-set output does not follow start");
  AST_RESET_OFF: assert property (@(posedge ref_clk) disable iff (rst) // RULE14
    iLvl.rstIn |=> !ctlOut)
    else $error("output on during reset input");
  AST_DOWN_HOLD: assert property (@(posedge ref_clk) disable iff (rst) // RULE12
    (down && st != T_IDLE && !clr && !iPrs.start && tickCnt != 32'(TICK - 1)
    && !zeroSets) |=> $stable(cnt))
    else $error("residual time moved without a tick");
  AST_KEY_CLEAR: assert property (@(posedge ref_clk) disable iff (rst) // RULE19
    (kPrs.rstKey && !lock && panel == P_NORMAL) |=> cnt == 16'h0000 && st == T_IDLE && !ctlOut)
    else $error("reset key did not clear timing");
endmodule

// ### bench/twt_operator.sv
// operator and contact model: turns bench commands into raw pin levels
// assumes commands from the bench, high meaning pressed or asserted
module twt_operator
  import twt_pkg::*;
(
  input wire twt_pkg::twt_keys_s keyCmd,
  input wire twt_pkg::twt_ins_s insCmd,
  output twt_pkg::twt_keys_s keysN,
  output twt_pkg::twt_ins_s insN
);
  timeunit 1ns;
  timeprecision 1ps;
  // level held as commanded
  // continuous so the pins are idle high from time zero, never unknown
  assign keysN = ~keyCmd;
  assign insN = ~insCmd;
endmodule

// ### bench/twt_panel_timer_tb.sv
// bench for the twin timer panel: bus tasks, key and contact scenarios
// assumes shortened counts WIDE 4, NARROW 2, CHECK 20, TICK 3
module twt_panel_timer_tb
  import twt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  twt_keys_s keyCmd = '0; // high = key pressed
  twt_ins_s insCmd = '0; // high = contact closed
  twt_keys_s keysN;
  twt_ins_s insN;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata, rdat;
  logic awready, wready, bvalid, arready, rvalid, ctlOut, showSel, lock;
  logic [1:0] bresp, rresp;
  logic [2:0] shownMode;
  int outCycles = 0; // cycles the output was seen on
  int oc; // output count at a reference point
  int fails = 0;
  int n_compared = 0;
  twt_operator twt_operator_inst (.keyCmd(keyCmd), .insCmd(insCmd), .keysN(keysN), .insN(insN));
  twt_panel_timer #(.WIDE(4), .NARROW(2), .CHECK(20), .TICK(3)) twt_panel_timer_inst (
    .ref_clk(ref_clk), .rst(rst), .keysN(keysN), .insN(insN),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .ctlOut(ctlOut), .showSel(showSel), .lock(lock), .shownMode(shownMode));
  // free-running 100 MHz clock
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  // counts output-on cycles so short pulses are not missed
  always @(posedge ref_clk) begin
    if (ctlOut === 1'b1) outCycles <= outCycles + 1;
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic hold(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // one write; each channel released at its own handshake edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge ref_clk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    bready <= 1'b1;
    forever begin
      @(posedge ref_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    chk("bresp", er, bresp);
  endtask
  // one read; data kept in rdat
  task automatic rd(input logic [7:0] a, input logic [1:0] er);
    @(posedge ref_clk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    forever begin
      @(posedge ref_clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    rdat = rdata;
    chk("rresp", er, rresp);
  endtask
  // key bit: fn 9, reset 8, up digit d 4+d, down digit d d
  function automatic twt_keys_s kb(input int b);
    return twt_keys_s'(10'h1 << b);
  endfunction
  // press and release one key, long enough for the width filter
  task automatic tap(input int b);
    @(posedge ref_clk);
    keyCmd <= kb(b);
    hold(20);
    keyCmd <= '0;
    hold(20);
  endtask
  // function key first, then the digit key; left held for a look
  task automatic combo(input int b);
    @(posedge ref_clk);
    keyCmd <= kb(9);
    hold(12);
    keyCmd <= twt_keys_s'(kb(b) | kb(9));
    hold(12);
  endtask
  task automatic rel;
    keyCmd <= '0;
    hold(20);
  endtask
  // short start pulse, three cycles wide
  task automatic pulse;
    @(posedge ref_clk);
    insCmd.start <= 1'b1;
    hold(3);
    insCmd.start <= 1'b0;
    hold(20);
  endtask
  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // watchdog: the sequence needs under 3000 cycles
  initial begin
    hold(20000);
    fails++;
    end_sim();
  end
  // main sequence
  initial begin
    hold(6);
    rst <= 1'b0;
    hold(2);
    chk("ctlOut", 0, ctlOut);
    rd(OFF_STAT, RESP_OKAY);
    chk("stat", 32'h240, rdat);
    rd(8'h20, RESP_DECERR);
    chk("unmapped", 0, rdat);
    wr(8'h20, 32'h1, RESP_DECERR);
    // zero set times: output follows the filtered start input
    pulse();
    chk("outCycles", 0, outCycles);
    wr(OFF_CTRL, 32'h2, RESP_OKAY);
    pulse();
    chk("outSeen", 1, outCycles != 0);
    wr(OFF_CTRL, 32'h0, RESP_OKAY);
    insCmd.start <= 1'b1;
    hold(20);
    chk("ctlOut", 1, ctlOut);
    insCmd.rstIn <= 1'b1;
    hold(20);
    chk("ctlOut", 0, ctlOut);
    insCmd <= '0;
    hold(20);
    // mode setting: enter, step, commit
    combo(4);
    rd(OFF_STAT, RESP_OKAY);
    chk("panel", 3'b010, rdat[8:6]);
    rel();
    repeat (3) tap(0);
    chk("shownMode", 3'h3, shownMode);
    tap(4);
    chk("shownMode", 3'h2, shownMode);
    tap(8);
    rd(OFF_STAT, RESP_OKAY);
    chk("panel mode", 6'b001010, rdat[8:3]);
    // mode check view, then back to normal
    combo(5);
    rd(OFF_STAT, RESP_OKAY);
    chk("panel", 3'b100, rdat[8:6]);
    chk("shownMode", 3'h2, shownMode);
    rel();
    rd(OFF_STAT, RESP_OKAY);
    chk("panel", 3'b001, rdat[8:6]);
    // set time editing on the shown interval
    tap(5);
    rd(OFF_SET1, RESP_OKAY);
    chk("set1", 32'h0a, rdat);
    tap(0);
    rd(OFF_SET1, RESP_OKAY);
    chk("set1", 32'h09, rdat);
    tap(9);
    chk("showSel", 1, showSel);
    rd(OFF_STAT, RESP_OKAY);
    chk("timer", 3'b001, rdat[11:9]);
    tap(6);
    rd(OFF_SET2, RESP_OKAY);
    chk("set2", 32'h64, rdat);
    rd(OFF_SET1, RESP_OKAY);
    chk("set1", 32'h09, rdat);
    // lock ignores edits, second combination releases it
    combo(7);
    rel();
    chk("lock", 1, lock);
    tap(6);
    rd(OFF_SET2, RESP_OKAY);
    chk("set2", 32'h64, rdat);
    combo(7);
    rel();
    chk("lock", 0, lock);
    tap(6);
    rd(OFF_SET2, RESP_OKAY);
    chk("set2", 32'hc8, rdat);
    // reset while idle, then a power-on mode start frozen by stop
    rst <= 1'b1;
    hold(2);
    rst <= 1'b0;
    hold(2);
    chk("showSel", 0, showSel);
    insCmd.stop <= 1'b1;
    hold(20);
    wr(OFF_CTRL, 32'h1, RESP_OKAY);
    wr(OFF_SET1, 32'h5, RESP_OKAY);
    rd(OFF_STAT, RESP_OKAY);
    chk("timer", 3'b010, rdat[11:9]);
    // lower edit while counting down keeps the residual
    wr(OFF_SET1, 32'h2, RESP_OKAY);
    rd(OFF_ELAP, RESP_OKAY);
    chk("residual", 32'h5, rdat);
    oc = outCycles;
    insCmd.stop <= 1'b0;
    hold(11);
    rd(OFF_ELAP, RESP_OKAY);
    chk("residual", 32'h3, rdat);
    chk("outEarly", 0, outCycles - oc);
    hold(12);
    chk("outRun2", 3, outCycles - oc);
    // unlocked reset key clears timing
    tap(8);
    rd(OFF_STAT, RESP_OKAY);
    chk("timer", 3'b001, rdat[11:9]);
    end_sim();
  end
endmodule
